// ---- include/aoc_params.svh ----
`ifndef AOC_PARAMS_SVH
`define AOC_PARAMS_SVH

// Register offsets (byte addresses, one word each)
`define AOC_OFS_ALM   8'h00
`define AOC_OFS_HYST  8'h04
`define AOC_OFS_WAIT  8'h08
`define AOC_OFS_SP    8'h0c
`define AOC_OFS_GATE  8'h10
`define AOC_OFS_TMR   8'h14
`define AOC_OFS_STAT  8'h18

// Field positions (least significant bit of each field)
`define AOC_ALM_TYPE  0
`define AOC_ALM_NC    3
`define AOC_ALM_SB    4
`define AOC_GATE_COMB 0
`define AOC_GATE_NC   2
`define AOC_GATE_S1   3
`define AOC_GATE_C1   8
`define AOC_GATE_S2   10
`define AOC_GATE_C2   15
`define AOC_TMR_SRC   0
`define AOC_TMR_MODE  5
`define AOC_TMR_NC    6
`define AOC_TMR_PRE   16
`define AOC_ST_ELAP   4

// Reset values and setting limits
`define AOC_HYST_RST  14'h0014
`define AOC_WAIT_RST  14'h0000
`define AOC_PRE_RST   13'h0000
`define AOC_SP_RST    16'h0000
`define AOC_HYST_MIN  16'h0001
`define AOC_HYST_MAX  16'h270f
`define AOC_WAIT_MAX  16'h270f
`define AOC_PRE_MAX   16'h1388

// Source select codes
`define AOC_SRC_TS1   5'h01
`define AOC_SRC_TS2L  5'h10
`define AOC_SRC_LAST  5'h1a

// Timing: clock rate in Hz, tick period and pulse length in seconds
`define AOC_CLK_HZ    250000000
`define AOC_SEC_S     1
`define AOC_PULSE_S   1

`endif

// ---- include/aoc_pkg.sv ----
package aoc_pkg;
  `include "aoc_params.svh"

  // Raw sources: channel-1 and channel-2 time signals, contact inputs
  typedef struct packed {
    logic [9:0] contact;
    logic [7:0] ts2;
    logic [7:0] ts1;
  } aoc_src_t;

  typedef enum logic [1:0] {
    AOC_PASS = 2'b00,
    AOC_NEG  = 2'b01,
    AOC_TGL  = 2'b10
  } aoc_cond_t;

  typedef enum logic [1:0] {
    AOC_AND = 2'b00,
    AOC_OR  = 2'b01,
    AOC_XOR = 2'b10
  } aoc_comb_t;

  typedef enum logic [1:0] {
    AOC_SB_OFF  = 2'b00,
    AOC_SB_RUN  = 2'b01,
    AOC_SB_SV   = 2'b10,
    AOC_SB_FOFF = 2'b11
  } aoc_sb_t;

  typedef enum logic {
    AOC_T_IDLE = 1'b0,
    AOC_T_RUN  = 1'b1
  } aoc_tmr_t;

  // State of one input conditioner
  typedef struct packed {
    logic [4:0] sel_d;
    aoc_cond_t  cond_d;
    logic       src_d;
    logic       latch;
    logic       level;
  } aoc_cond_state_t;

  // State of the whole block
  typedef struct packed {
    logic [27:0]        tick_cnt;
    logic [2:0]         alm_type;
    logic               alm_nc;
    aoc_sb_t            sb;
    logic [13:0]        hyst;
    logic [13:0]        wait_set;
    logic signed [15:0] alm_sp;
    aoc_comb_t          comb;
    logic               gate_nc;
    logic [4:0]         first_source;
    aoc_cond_t          cond1;
    logic [4:0]         second_source;
    aoc_cond_t          cond2;
    logic [4:0]         tsrc;
    logic               tmode;
    logic               tnc;
    logic [12:0]        preset;
    logic               cause;
    logic               standby;
    logic [13:0]        elapsed;
    logic               halted_d;
    logic signed [15:0] sv_d;
    aoc_tmr_t           tstate;
    logic [12:0]        tcount;
    logic               tsrc_d;
    logic [27:0]        pulse_cnt;
    logic               pulse_act;
    logic               alm_act;
    logic               alm_out;
    logic               gate_out;
    logic               pulse_out;
    logic [31:0]        rd_data;
  } aoc_state_t;

  function automatic logic [15:0] aoc_clamp(input logic [15:0] v, lo, hi);
    aoc_clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  function automatic logic aoc_is_ts(input logic [4:0] s);
    aoc_is_ts = (s >= `AOC_SRC_TS1) && (s <= `AOC_SRC_TS2L);
  endfunction

  // Toggle conditioning is refused on time-signal sources
  function automatic aoc_cond_t aoc_fix_cond(input logic [4:0] s, input logic [1:0] c);
    aoc_fix_cond = (c == AOC_TGL && aoc_is_ts(s)) ? AOC_PASS :
                   ((c == 2'b11) ? AOC_PASS : aoc_cond_t'(c));
  endfunction
endpackage

// ---- rtl/aoc_input_cond.sv ----
`timescale 1ns/10ps
`include "aoc_params.svh"
// Selects one source and applies pass-through, negate or toggle latch
module aoc_input_cond (
  input  wire logic              clk_i,
  input  wire aoc_pkg::aoc_src_t src_i,
  input  wire logic              reset_i,
  input  wire logic [4:0]        sel_i,
  input  wire logic [1:0]        cond_i,
  output logic                   level_o
);
  aoc_pkg::aoc_cond_state_t r;   // Registered state
  aoc_pkg::aoc_cond_state_t n;   // Next state
  logic [25:0]              all_c; // Flattened sources
  logic                     raw_c; // Selected source level

  assign all_c = src_i;

  // Source select: none never activates
  always_comb begin
    raw_c = 1'b0;
    if (sel_i != 5'h00 && sel_i <= `AOC_SRC_LAST) begin
      raw_c = all_c[sel_i - 5'h01]; // R12
    end
  end

  // Conditioning and toggle latch
  always_comb begin
    n          = r;
    n.src_d    = raw_c;
    n.sel_d    = sel_i;
    n.cond_d   = aoc_pkg::aoc_cond_t'(cond_i);
    if (sel_i != r.sel_d || cond_i != r.cond_d) begin
      n.latch = 1'b0; // R23
    end else if (raw_c && !r.src_d) begin
      n.latch = !r.latch; // R13
    end
    unique case (aoc_pkg::aoc_cond_t'(cond_i))
      aoc_pkg::AOC_NEG: n.level = !raw_c; // R13
      aoc_pkg::AOC_TGL: n.level = n.latch; // R13
      default:          n.level = raw_c;
    endcase
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign level_o = r.level;
endmodule

// ---- rtl/aoc_alarm_cond.sv ----
`timescale 1ns/10ps
`include "aoc_params.svh"
//
// Contract
// R1: output sense maps idle action to contact state
// R2: hysteresis band 1..9999, default 20
// R3: alarm only after wait interval elapses
// R4: cause loss aborts wait, restart from zero
// R5: wait OFF asserts at once
// R6: wait change keeps original elapsed count
// R7: standby suppresses until leave and re-entry
// R8: standby arms at power-up, run, target change
// R9: range fault forces on, or off for 3
// R10: gate drives its output from two inputs
// R11: combine AND, OR or XOR, AND default
// R12: source none, time signals or contacts
// R13: pass, negate or toggle conditioning
// R14: toggle refused on time-signal sources
// R15: NAND/NOR via negate plus inverted sense
// R16: timer/counter output with source and mode
// R17: timer/counter free-running, one-second pulse
// R18: timer fires preset seconds after activation
// R19: counter fires at preset activation count
// R20: comparison events inactive while halted
// R21: one-second tick from clock, sync reset
// R22: low/high limits with hysteresis turn-off
// R23: changing source or mode clears latches
module aoc_alarm_cond #(
  parameter int unsigned SEC_CYCLES = `AOC_SEC_S * `AOC_CLK_HZ
) (
  input  wire logic               clk_i,
  input  wire logic               reset_i,
  input  wire logic [7:0]         addr_i,
  input  wire logic [31:0]        wr_data_i,
  input  wire logic               wr_en_i,
  input  wire logic               rd_en_i,
  output logic [31:0]             rd_data_o,
  input  wire logic signed [15:0] measured_value_i,
  input  wire logic signed [15:0] target_value_i,
  input  wire logic               halted_i,
  input  wire logic               range_fault_i,
  input  wire aoc_pkg::aoc_src_t  src_i,
  output logic                    alarm_line_o,
  output logic                    gate_line_o,
  output logic                    pulse_line_o
);
  localparam int unsigned PULSE_CYCLES = `AOC_PULSE_S * SEC_CYCLES;

  aoc_pkg::aoc_state_t r;        // Registered state
  aoc_pkg::aoc_state_t n;        // Next state
  logic                tick_c;   // One-second enable
  logic                in1_c;    // First conditioned gate input
  logic                in2_c;    // Second conditioned gate input
  logic                tin_c;    // Timer/counter source level
  logic signed [17:0]  dev_c;    // Measured minus target
  logic signed [17:0]  x_c;      // Compared quantity
  logic signed [17:0]  sp_c;     // Alarm set point
  logic signed [17:0]  hy_c;     // Hysteresis band
  logic                valid_c;  // Comparison event type selected
  logic                on_c;     // Turn-on threshold crossed
  logic                keep_c;   // Still inside hysteresis
  logic                cause_c;  // Event cause after hysteresis
  logic                sb_on_c;  // Standby choice uses standby
  logic                arm_c;    // Standby arming event
  logic                sby_c;    // Standby holds off action
  logic                qual_c;   // Cause not held off by standby
  logic                act_c;    // Alarm action this cycle
  logic                comb_c;   // Gate combined result

  // Gate input conditioners
  aoc_input_cond u_in1 (
    .clk_i   (clk_i),
    .src_i   (src_i),
    .reset_i (reset_i),
    .sel_i   (r.first_source),
    .cond_i  (r.cond1),
    .level_o (in1_c)
  );

  aoc_input_cond u_in2 (
    .clk_i   (clk_i),
    .src_i   (src_i),
    .reset_i (reset_i),
    .sel_i   (r.second_source),
    .cond_i  (r.cond2),
    .level_o (in2_c)
  );

  // Timer/counter source, always pass-through
  aoc_input_cond u_tin (
    .clk_i   (clk_i),
    .src_i   (src_i),
    .reset_i (reset_i),
    .sel_i   (r.tsrc),
    .cond_i  (aoc_pkg::AOC_PASS),
    .level_o (tin_c)
  );

  // Tick at the end of each second
  assign tick_c = (r.tick_cnt == 28'(SEC_CYCLES - 1)); // R21

  // Comparison quantity: deviation, its magnitude, or measured value
  assign dev_c   = 18'(measured_value_i) - 18'(target_value_i);
  assign x_c     = (r.alm_type[2] && r.alm_type[1]) ? 18'(measured_value_i) :
                   ((r.alm_type[2] && dev_c[17]) ? -dev_c : dev_c);
  assign sp_c    = 18'(r.alm_sp);
  assign hy_c    = 18'($signed({1'b0, r.hyst}));
  assign valid_c = (r.alm_type >= 3'h2);

  // Low types turn on below, off above point plus band; high mirrors
  assign on_c    = r.alm_type[0] ? (x_c < sp_c) : (x_c > sp_c); // R22
  assign keep_c  = r.alm_type[0] ? (x_c <= sp_c + hy_c)
                                 : (x_c >= sp_c - hy_c); // R2
  assign cause_c = valid_c && !halted_i && (r.cause ? keep_c : on_c); // R20

  // Standby arms at run entry or, for choice 2, target change
  assign sb_on_c = (r.sb == aoc_pkg::AOC_SB_RUN) || (r.sb == aoc_pkg::AOC_SB_SV);
  assign arm_c   = sb_on_c && ((r.halted_d && !halted_i) ||
                   (r.sb == aoc_pkg::AOC_SB_SV && r.sv_d != target_value_i)); // R8
  assign sby_c   = arm_c || (r.standby && cause_c && sb_on_c); // R7
  assign qual_c  = cause_c && !sby_c;

  // Range fault overrides; otherwise wait against elapsed seconds
  always_comb begin
    if (range_fault_i && valid_c) begin
      act_c = (r.sb != aoc_pkg::AOC_SB_FOFF); // R9
    end else begin
      act_c = qual_c && (r.wait_set == 14'h0000 || // R5
                         r.elapsed >= r.wait_set); // R3 R6
    end
  end

  // Two-input combiner
  always_comb begin
    unique case (r.comb)
      aoc_pkg::AOC_OR:  comb_c = in1_c | in2_c; // R11
      aoc_pkg::AOC_XOR: comb_c = in1_c ^ in2_c; // R11
      default:          comb_c = in1_c & in2_c; // R11
    endcase
  end

  // Next-state logic for the whole block
  always_comb begin
    logic fire;
    logic trise;
    fire  = 1'b0;
    trise = tin_c && !r.tsrc_d;
    n     = r;
    // Second divider
    n.tick_cnt = tick_c ? 28'h0000000 : r.tick_cnt + 28'h0000001; // R21
    // Comparison alarm
    n.cause    = cause_c;
    n.standby  = sby_c;
    n.halted_d = halted_i;
    n.sv_d     = target_value_i;
    if (!qual_c) begin
      n.elapsed = 14'h0000; // R4
    end else if (tick_c && r.elapsed != `AOC_WAIT_MAX) begin
      n.elapsed = r.elapsed + 14'h0001; // R6
    end
    n.alm_act  = act_c;
    n.alm_out  = act_c ^ r.alm_nc; // R1
    // Gate output; inverted sense turns AND/OR into NAND/NOR
    n.gate_out = comb_c ^ r.gate_nc; // R10 R15
    // Timer and counter, independent of run state
    n.tsrc_d = tin_c;
    if (!r.tmode) begin
      unique case (r.tstate)
        // Timer starts on a source rise
        aoc_pkg::AOC_T_IDLE: begin
          if (trise && r.preset != 13'h0000) begin
            n.tstate = aoc_pkg::AOC_T_RUN; // R18
            n.tcount = 13'h0000;
          end
        end
        aoc_pkg::AOC_T_RUN: begin
          if (tick_c) begin
            if (r.tcount + 13'h0001 == r.preset) begin
              fire     = 1'b1; // R18
              n.tstate = aoc_pkg::AOC_T_IDLE;
            end else begin
              n.tcount = r.tcount + 13'h0001;
            end
          end
        end
      endcase
    end else if (trise && r.preset != 13'h0000) begin
      // Counter fires on the preset-th rise
      if (r.tcount + 13'h0001 == r.preset) begin
        fire     = 1'b1; // R19
        n.tcount = 13'h0000;
      end else begin
        n.tcount = r.tcount + 13'h0001; // R19
      end
    end
    // One-second output pulse
    if (fire) begin
      n.pulse_cnt = 28'(PULSE_CYCLES - 1); // R17
      n.pulse_act = 1'b1;
    end else if (r.pulse_cnt != 28'h0000000) begin
      n.pulse_cnt = r.pulse_cnt - 28'h0000001;
    end else begin
      n.pulse_act = 1'b0;
    end
    n.pulse_out = n.pulse_act ^ r.tnc; // R1 R16
    // Register writes
    if (wr_en_i) begin
      case (addr_i)
        `AOC_OFS_ALM: begin
          n.alm_type = wr_data_i[`AOC_ALM_TYPE +: 3];
          n.alm_nc   = wr_data_i[`AOC_ALM_NC]; // R1
          n.sb       = aoc_pkg::aoc_sb_t'(wr_data_i[`AOC_ALM_SB +: 2]); // R8
        end
        `AOC_OFS_HYST: begin
          n.hyst = 14'(aoc_pkg::aoc_clamp(wr_data_i[15:0],
                       `AOC_HYST_MIN, `AOC_HYST_MAX)); // R2
        end
        `AOC_OFS_WAIT: begin
          n.wait_set = 14'(aoc_pkg::aoc_clamp(wr_data_i[15:0],
                           16'h0000, `AOC_WAIT_MAX)); // R3
        end
        `AOC_OFS_SP: begin
          n.alm_sp = wr_data_i[15:0];
        end
        `AOC_OFS_GATE: begin
          n.comb    = (wr_data_i[`AOC_GATE_COMB +: 2] == 2'b11) ? aoc_pkg::AOC_AND :
                      aoc_pkg::aoc_comb_t'(wr_data_i[`AOC_GATE_COMB +: 2]);
          n.gate_nc = wr_data_i[`AOC_GATE_NC];
          n.first_source    = wr_data_i[`AOC_GATE_S1 +: 5];
          n.second_source    = wr_data_i[`AOC_GATE_S2 +: 5];
          n.cond1   = aoc_pkg::aoc_fix_cond(wr_data_i[`AOC_GATE_S1 +: 5],
                        wr_data_i[`AOC_GATE_C1 +: 2]); // R14
          n.cond2   = aoc_pkg::aoc_fix_cond(wr_data_i[`AOC_GATE_S2 +: 5],
                        wr_data_i[`AOC_GATE_C2 +: 2]); // R14
        end
        `AOC_OFS_TMR: begin
          n.tsrc   = wr_data_i[`AOC_TMR_SRC +: 5]; // R16
          n.tmode  = wr_data_i[`AOC_TMR_MODE];
          n.tnc    = wr_data_i[`AOC_TMR_NC];
          n.preset = 13'(aoc_pkg::aoc_clamp(wr_data_i[`AOC_TMR_PRE +: 16],
                         16'h0000, `AOC_PRE_MAX));
          if (n.tsrc != r.tsrc || n.tmode != r.tmode) begin
            n.tcount = 13'h0000; // R23
            n.tstate = aoc_pkg::AOC_T_IDLE;
          end
        end
        default: begin
          // Unmapped offsets are ignored
        end
      endcase
    end
    // Register reads, data valid in the following cycle only
    n.rd_data = 32'h00000000;
    if (rd_en_i) begin
      case (addr_i)
        `AOC_OFS_ALM:  n.rd_data = 32'({r.sb, r.alm_nc, r.alm_type});
        `AOC_OFS_HYST: n.rd_data = 32'(r.hyst);
        `AOC_OFS_WAIT: n.rd_data = 32'(r.wait_set);
        `AOC_OFS_SP:   n.rd_data = 32'(unsigned'(r.alm_sp));
        `AOC_OFS_GATE: n.rd_data = 32'({r.cond2, r.second_source, r.cond1, r.first_source,
                                         r.gate_nc, r.comb});
        `AOC_OFS_TMR:  n.rd_data = {3'h0, r.preset, 9'h000, r.tnc, r.tmode, r.tsrc};
        `AOC_OFS_STAT: n.rd_data = 32'({r.elapsed, r.pulse_act, r.gate_out,
                                         r.standby, r.alm_act});
        default:       n.rd_data = 32'h00000000;
      endcase
    end
  end

  // State register with synchronous reset; standby armed at power-up
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      r          <= '0;
      r.hyst     <= `AOC_HYST_RST; // R2
      r.wait_set <= `AOC_WAIT_RST;
      r.preset   <= `AOC_PRE_RST;
      r.alm_sp   <= `AOC_SP_RST;
      r.standby  <= 1'b1; // R8
    end else begin
      r <= n;
    end
  end

  assign rd_data_o    = r.rd_data;
  assign alarm_line_o = r.alm_out;
  assign gate_line_o  = r.gate_out;
  assign pulse_line_o = r.pulse_out;

  // Checks
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);


  // Inactive action shows the idle contact state
  sense_idle_a: assert property ( // R1
    (!valid_c && !wr_en_i) |=> alarm_line_o == $past(r.alm_nc))
    else $error("idle alarm line does not follow sense");

  // No action before the wait runs out
  wait_block_a: assert property ( // R3
    (qual_c && !range_fault_i && r.wait_set != 14'h0000 &&
     r.elapsed < r.wait_set) |=> !r.alm_act)
    else $error("alarm asserted before wait elapsed");

  // Lost cause restarts the wait
  wait_clear_a: assert property ( // R4
    !qual_c |=> r.elapsed == 14'h0000)
    else $error("elapsed count not cleared on cause loss");

  // Wait off acts on the next edge
  wait_off_a: assert property ( // R5
    (qual_c && !range_fault_i && r.wait_set == 14'h0000) |=> r.alm_act)
    else $error("alarm not immediate with wait off");

  // Standby keeps the action off
  standby_hold_a: assert property ( // R7
    (sby_c && !range_fault_i) |=> !r.alm_act ##0 r.standby)
    else $error("alarm not suppressed in standby");

  // Range fault forces on, or off for choice 3
  fault_force_a: assert property ( // R9
    (range_fault_i && valid_c) |=>
      r.alm_act == ($past(r.sb) != aoc_pkg::AOC_SB_FOFF))
    else $error("range fault forcing wrong");

  // Halted controller silences comparisons
  halted_off_a: assert property ( // R20
    (halted_i && !range_fault_i) |=> !r.cause ##0 !r.alm_act)
    else $error("comparison event active while halted");

  // Time-signal source on the first gate input never latches
  toggle_ts_a: assert property ( // R14
    aoc_pkg::aoc_is_ts(r.first_source) |-> r.cond1 != aoc_pkg::AOC_TGL)
    else $error("toggle latch on time signal source");

  // Pulse starts with a full second loaded
  pulse_len_a: assert property ( // R17
    $rose(r.pulse_act) |-> r.pulse_cnt == 28'(PULSE_CYCLES - 1))
    else $error("pulse length not one second");

  // AND mode with both inputs active drives the gate
  gate_and_a: assert property ( // R11
    (r.comb == aoc_pkg::AOC_AND && in1_c && in2_c && !r.gate_nc)
      |=> gate_line_o)
    else $error("AND combine failed");

  alarm_rise_c: cover property ($rose(r.alm_act));
  pulse_rise_c: cover property ($rose(r.pulse_act));
  gate_rise_c:  cover property ($rose(r.gate_out));
  // Standby arming and range fault forcing
  standby_arm_c: cover property (arm_c && cause_c);
  fault_force_c: cover property (range_fault_i && valid_c);
endmodule

// ---- bench/aoc_field_model.sv ----
`timescale 1ns/10ps
// Far side: contact switches, time-signal sources and a load on the pulse line
module aoc_field_model (
  input  wire logic         clk_i,
  input  wire logic [9:0]   contact_i,
  input  wire logic [7:0]   ts_i,
  input  wire logic         pulse_line_i,
  output aoc_pkg::aoc_src_t src_o,
  output logic [31:0]       pulse_len_o
);
  logic [31:0] run_r = 32'h0;  // Cycles the load has been energised
  logic [31:0] len_r = 32'h0;  // Width of the last finished pulse

  // Channel two sees the inverse pattern so the two channels differ
  assign src_o = '{contact: contact_i, ts2: ~ts_i, ts1: ts_i};
  assign pulse_len_o = len_r;

  // Load measures how long each pulse keeps it energised
  always @(posedge clk_i) begin
    if (pulse_line_i) begin
      run_r <= run_r + 32'h1;
    end else begin
      if (run_r != 32'h0) begin
        len_r <= run_r;
      end
      run_r <= 32'h0;
    end
  end
endmodule

// ---- bench/aoc_alarm_cond_tb_top.sv ----
`timescale 1ns/10ps
`include "aoc_params.svh"
// Self-checking bench for the alarm output conditioning block
module aoc_alarm_cond_tb_top;
  localparam int SEC = 8;               // Shortened second in cycles
  logic               clk_i   = 1'b0;   // 250 MHz clock
  logic               reset_i = 1'b1;   // Synchronous reset
  logic [7:0]         addr    = 8'h00;  // Register address
  logic [31:0]        wdata   = 32'h0;  // Write data
  logic               wr_en   = 1'b0;   // Write strobe
  logic               rd_en   = 1'b0;   // Read strobe
  logic [31:0]        rdata;            // Read data
  logic signed [15:0] mv      = 16'sh00c8; // Measured value, idle high
  logic signed [15:0] tv      = 16'sh0;    // Target value
  logic               halted  = 1'b0;   // Controller halted
  logic               fault   = 1'b0;   // Range fault
  logic [9:0]         contact = 10'h0;  // Contact switches
  logic [7:0]         ts      = 8'h0;   // Time signals
  aoc_pkg::aoc_src_t  src;              // Source bundle
  logic               alarm;            // Alarm line
  logic               gate;             // Gate line
  logic               pulse;            // Timer/counter line
  logic [31:0]        plen;             // Last pulse width
  logic [31:0]        tmp;              // Read-back scratch
  int                 errors      = 0;
  int                 comparisons = 0;

  always #2 clk_i = ~clk_i;

  aoc_alarm_cond #(.SEC_CYCLES(SEC)) aoc_alarm_cond_i (
    .clk_i(clk_i), .reset_i(reset_i), .addr_i(addr), .wr_data_i(wdata),
    .wr_en_i(wr_en), .rd_en_i(rd_en), .rd_data_o(rdata),
    .measured_value_i(mv), .target_value_i(tv), .halted_i(halted),
    .range_fault_i(fault), .src_i(src), .alarm_line_o(alarm),
    .gate_line_o(gate), .pulse_line_o(pulse));

  aoc_field_model aoc_field_model_i (
    .clk_i(clk_i), .contact_i(contact), .ts_i(ts), .pulse_line_i(pulse),
    .src_o(src), .pulse_len_o(plen));

  // Compare and count
  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask

  // Let n edges pass, then sample settled outputs
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // One-cycle register write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk_i);
    wr_en <= 1'b0;
  endtask

  // One-cycle register read, data taken in the following cycle
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk_i);
    rd_en <= 1'b0;
    #1;
    d = rdata;
  endtask

  // Alarm configuration: type, closed-when-idle, standby choice
  task automatic alm(input logic [2:0] t, input logic nc, input logic [1:0] sb);
    wr(`AOC_OFS_ALM, {26'h0, sb, nc, t});
  endtask

  // Move the measured value and check the alarm line
  task automatic mvchk(input logic signed [15:0] v, input logic exp);
    @(posedge clk_i);
    mv <= v;
    step(3);
    check("alarm", {31'h0, alarm}, {31'h0, exp});
  endtask

  // One press of a contact
  task automatic bump(input int i);
    @(posedge clk_i);
    contact[i] <= 1'b1;
    step(2);
    @(posedge clk_i);
    contact[i] <= 1'b0;
    step(3);
  endtask

  task automatic t_regs;
    rd(`AOC_OFS_HYST, tmp);
    check("hyst reset", tmp, 32'h14);
    rd(`AOC_OFS_WAIT, tmp);
    check("wait reset", tmp, 32'h0);
    rd(8'h20, tmp);
    check("unmapped", tmp, 32'h0);
    wr(`AOC_OFS_HYST, 32'h0);
    rd(`AOC_OFS_HYST, tmp);
    check("hyst min", tmp, 32'h1);
    wr(`AOC_OFS_HYST, 32'hffff);
    rd(`AOC_OFS_HYST, tmp);
    check("hyst max", tmp, 32'h270f);
    $display("test regs done");
  endtask

  task automatic t_limit;
    wr(`AOC_OFS_SP, 32'h64);
    wr(`AOC_OFS_HYST, 32'h5);
    alm(3'h7, 1'b0, 2'h0);
    mvchk(16'sh0064, 1'b0);
    mvchk(16'sh0063, 1'b1);
    mvchk(16'sh0069, 1'b1);
    mvchk(16'sh006a, 1'b0);
    alm(3'h7, 1'b1, 2'h0);
    mvchk(16'sh006a, 1'b1);
    mvchk(16'sh0050, 1'b0);
    alm(3'h7, 1'b0, 2'h0);
    @(posedge clk_i);
    halted <= 1'b1;
    mvchk(16'sh0050, 1'b0);
    @(posedge clk_i);
    halted <= 1'b0;
    mvchk(16'sh0050, 1'b1);
    mvchk(16'sh006a, 1'b0);
    $display("test limit done");
  endtask

  task automatic t_wait;
    wr(`AOC_OFS_WAIT, 32'h3);
    mvchk(16'sh0063, 1'b0);
    step(SEC - 3);
    check("wait early", {31'h0, alarm}, 32'h0);
    mvchk(16'sh006a, 1'b0);
    mvchk(16'sh0063, 1'b0);
    step(2 * SEC - 3);
    check("wait restart", {31'h0, alarm}, 32'h0);
    wr(`AOC_OFS_WAIT, 32'h2);
    step(4);
    check("wait change", {31'h0, alarm}, 32'h1);
    mvchk(16'sh006a, 1'b0);
    wr(`AOC_OFS_WAIT, 32'h0);
    $display("test wait done");
  endtask

  task automatic t_standby;
    alm(3'h7, 1'b0, 2'h1);
    // Value already in range when run is entered
    @(posedge clk_i);
    halted <= 1'b1;
    mvchk(16'sh0063, 1'b0);
    @(posedge clk_i);
    halted <= 1'b0;
    mvchk(16'sh0063, 1'b0);
    mvchk(16'sh006a, 1'b0);
    mvchk(16'sh0063, 1'b1);
    @(posedge clk_i);
    tv <= 16'sh0009;
    mvchk(16'sh0063, 1'b1);
    alm(3'h7, 1'b0, 2'h2);
    @(posedge clk_i);
    tv <= 16'sh0005;
    mvchk(16'sh0063, 1'b0);
    mvchk(16'sh006a, 1'b0);
    mvchk(16'sh0063, 1'b1);
    alm(3'h7, 1'b0, 2'h0);
    @(posedge clk_i);
    halted <= 1'b1;
    step(2);
    @(posedge clk_i);
    halted <= 1'b0;
    mvchk(16'sh0063, 1'b1);
    $display("test standby done");
  endtask

  task automatic t_fault;
    @(posedge clk_i);
    fault <= 1'b1;
    mvchk(16'sh006a, 1'b1);
    alm(3'h7, 1'b0, 2'h3);
    mvchk(16'sh0063, 1'b0);
    @(posedge clk_i);
    fault <= 1'b0;
    mvchk(16'sh006a, 1'b0);
    $display("test fault done");
  endtask

  task automatic t_gate;
    logic a;
    logic b;
    logic n;
    logic r;
    // Every mode, every input pair, plain and with both inputs and sense inverted
    for (int m = 0; m < 3; m++) begin
      for (int v = 0; v < 8; v++) begin
        n = v[2];
        wr(`AOC_OFS_GATE, {15'h0, 1'b0, n, 5'h12, 1'b0, n, 5'h11, n, m[1:0]});
        @(posedge clk_i);
        contact[1:0] <= v[1:0];
        step(3);
        a = v[0] ^ n;
        b = v[1] ^ n;
        r = (m == 0) ? (a & b) : ((m == 1) ? (a | b) : (a ^ b));
        check("gate", {31'h0, gate}, {31'h0, r ^ n});
      end
    end
    @(posedge clk_i);
    contact <= 10'h0;
    // Toggle on a contact, second input none
    wr(`AOC_OFS_GATE, {15'h0, 2'h0, 5'h00, 2'h2, 5'h11, 1'b0, 2'h1});
    step(3);
    check("none input", {31'h0, gate}, 32'h0);
    bump(0);
    check("toggle on", {31'h0, gate}, 32'h1);
    bump(0);
    check("toggle off", {31'h0, gate}, 32'h0);
    wr(`AOC_OFS_GATE, {15'h0, 2'h0, 5'h00, 2'h2, 5'h01, 1'b0, 2'h1});
    rd(`AOC_OFS_GATE, tmp);
    check("toggle on ts", {30'h0, tmp[9:8]}, 32'h0);
    // Time signal passes straight through, no latching
    @(posedge clk_i);
    ts[0] <= 1'b1;
    step(3);
    check("ts level", {31'h0, gate}, 32'h1);
    @(posedge clk_i);
    ts[0] <= 1'b0;
    step(3);
    check("ts no latch", {31'h0, gate}, 32'h0);
    $display("test gate done");
  endtask

  task automatic t_timer;
    int n;
    n = 0;
    wr(`AOC_OFS_TMR, {3'h0, 13'h0002, 9'h0, 1'b0, 1'b0, 5'h13});
    @(posedge clk_i);
    halted <= 1'b1;
    contact[2] <= 1'b1;
    step(1);
    while (pulse !== 1'b1 && n < 60) begin
      step(1);
      n++;
    end
    check("timer delay", 32'(n >= SEC + 1 && n <= 2 * SEC + 5), 32'h1);
    step(SEC + 3);
    check("pulse width", plen, 32'(SEC));
    @(posedge clk_i);
    contact[2] <= 1'b0;
    halted <= 1'b0;
    wr(`AOC_OFS_TMR, {3'h0, 13'h0003, 9'h0, 1'b0, 1'b1, 5'h14});
    bump(3);
    bump(3);
    check("count two", {31'h0, pulse}, 32'h0);
    bump(3);
    check("count three", {31'h0, pulse}, 32'h1);
    step(SEC + 3);
    check("count pulse", plen, 32'(SEC));
    $display("test timer done");
  endtask

  // Summary, verdict and end of run
  task automatic end_of_test;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    t_regs();
    t_limit();
    t_wait();
    t_standby();
    t_fault();
    t_gate();
    t_timer();
    end_of_test();
  end

  // Watchdog well beyond the expected run length
  initial begin
    repeat (5000) @(posedge clk_i);
    errors++;
    end_of_test();
  end
endmodule
